// File: design/ccr_top.v
// Two composite clock receivers with clock recovery and line fault detection.
`timescale 1ns/10ps
`include "ccr_regs.vh"

module ccr_top #(
  parameter [19:0] NO8K_CYCLES = `CCR_NO8K_CYCLES,
  parameter [19:0] NO400_CYCLES = `CCR_NO400_CYCLES,
  parameter [19:0] HALF8K_CYCLES = `CCR_HALF8K_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [1:0] cc_pos_pulse,
  input wire [1:0] cc_neg_pulse,
  input wire [1:0] logic_clk_in,
  input wire first_input_format_select,
  input wire second_input_format_select,
  input wire recovered_edge_select,
  input wire bit_error_count_enable,
  input wire ami_invalidate_enable,
  input wire los_invalidate_enable,
  input wire [3:0] line_fault_irq_enable,
  input wire [3:0] component_irq_enable,
  input wire [3:0] line_fault_status_clear,
  input wire [3:0] component_status_clear,
  output wire [3:0] line_fault_status_register,
  output wire [3:0] component_status_register,
  output wire [1:0] recovered_clk_out,
  output wire [1:0] clock_invalid,
  output wire [1:0] leaky_bucket_inc,
  output wire [1:0] missing_8k_active,
  output wire interrupt_request_out
);

  localparam [19:0] LOS_CYCLES = `CCR_LOS_CYCLES;
  localparam [19:0] ONE = 20'h00001;

  // Saturating increment for the interval timers.
  function [19:0] sat_inc;
    input [19:0] v;
    begin
      sat_inc = (v == 20'hFFFFF) ? v : v + ONE;
    end
  endfunction

  wire [1:0] s_pos;
  wire [1:0] s_neg;
  wire [1:0] los_set;
  wire [1:0] ami_set;
  wire [1:0] no8k_set;
  wire [1:0] no400_set;
  wire [3:0] lf_set;
  wire [3:0] cs_set;

  // Format mode, 1 means logic-level clock; resets to composite reception.
  reg [1:0] fmt_logic_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_logic_reg <= `CCR_FORMAT_RST;
    end else begin
      fmt_logic_reg <= {second_input_format_select, first_input_format_select};
    end
  end

  ccr_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({cc_neg_pulse, cc_pos_pulse}),
    .q({s_neg, s_pos})
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
      reg prev_pos_reg;
      reg prev_neg_reg;
      reg last_pol_reg;
      reg have_pol_reg;
      reg [3:0] mark_cnt_reg;
      reg prev_err_reg;
      reg ami_active_reg;
      reg [19:0] los_cnt_reg;
      reg los_active_reg;
      reg [19:0] no8k_cnt_reg;
      reg no8k_active_reg;
      reg [19:0] no400_cnt_reg;
      reg no400_active_reg;
      reg after_bpv_reg;
      reg [19:0] half_cnt_reg;
      reg rclk_reg;
      reg fwd_reg;
      reg invalid_reg;
      reg bucket_reg;

      wire pulse_p;
      wire pulse_n;
      wire pulse;
      wire pol;
      wire bpv;
      wire [3:0] cnt_new;
      wire frame_end;
      wire frame_good;
      wire frame_err;
      wire omitted;
      wire omit_event;
      wire ami_declare;
      wire edge_event;

      // Leading edges of the synchronised positive and negative marks.
      assign pulse_p = s_pos[gi] & ~prev_pos_reg;
      assign pulse_n = s_neg[gi] & ~prev_neg_reg;
      assign pulse = pulse_p | pulse_n;
      assign pol = pulse_p;

      // A violation repeats the polarity of the previous mark.
      assign bpv = pulse & have_pol_reg & (pol == last_pol_reg);
      assign cnt_new = mark_cnt_reg + 4'h1;

      // A frame closes on a violation or on the eighth mark without one.
      assign frame_end = bpv | (pulse & (cnt_new == `CCR_MARKS_PER_FRAME));
      assign frame_good = bpv & (cnt_new == `CCR_MARKS_PER_FRAME);
      assign frame_err = frame_end & ~frame_good;
      assign omitted = frame_end & ~bpv;
      // An omitted violation after a good frame marks the 400 Hz component.
      assign omit_event = omitted & ~prev_err_reg;
      assign ami_declare = frame_err & prev_err_reg;

      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          prev_pos_reg <= 1'b0;
          prev_neg_reg <= 1'b0;
          last_pol_reg <= 1'b0;
          have_pol_reg <= 1'b0;
          mark_cnt_reg <= 4'h0;
          prev_err_reg <= 1'b0;
          ami_active_reg <= 1'b0;
        end else begin
          prev_pos_reg <= s_pos[gi];
          prev_neg_reg <= s_neg[gi];
          if (pulse) begin
            last_pol_reg <= pol;
            have_pol_reg <= 1'b1;
          end
          if (frame_end) begin
            mark_cnt_reg <= 4'h0;
            prev_err_reg <= frame_err;
          end else if (pulse) begin
            mark_cnt_reg <= cnt_new;
          end
          if (ami_declare) begin
            ami_active_reg <= 1'b1;
          end else if (frame_good) begin
            ami_active_reg <= 1'b0;
          end
        end
      end

      // Interval timers for loss of signal and the two components.
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          los_cnt_reg <= 20'h00000;
          los_active_reg <= 1'b0;
          no8k_cnt_reg <= 20'h00000;
          no8k_active_reg <= 1'b0;
          no400_cnt_reg <= 20'h00000;
          no400_active_reg <= 1'b0;
        end else begin
          if (pulse) begin
            los_cnt_reg <= 20'h00000;
            los_active_reg <= 1'b0;
          end else begin
            los_cnt_reg <= sat_inc(los_cnt_reg);
            if (los_cnt_reg == LOS_CYCLES - ONE) begin
              los_active_reg <= 1'b1;
            end
          end
          if (bpv) begin
            no8k_cnt_reg <= 20'h00000;
            no8k_active_reg <= 1'b0;
          end else begin
            no8k_cnt_reg <= sat_inc(no8k_cnt_reg);
            if (no8k_cnt_reg == NO8K_CYCLES - ONE) begin
              no8k_active_reg <= 1'b1;
            end
          end
          if (omit_event) begin
            no400_cnt_reg <= 20'h00000;
            no400_active_reg <= 1'b0;
          end else begin
            no400_cnt_reg <= sat_inc(no400_cnt_reg);
            if (no400_cnt_reg == NO400_CYCLES - ONE) begin
              no400_active_reg <= 1'b1;
            end
          end
        end
      end

      assign los_set[gi] = ~pulse & ~los_active_reg & (los_cnt_reg == LOS_CYCLES - ONE);
      assign no8k_set[gi] = ~bpv & ~no8k_active_reg & (no8k_cnt_reg == NO8K_CYCLES - ONE);
      assign no400_set[gi] = ~omit_event & ~no400_active_reg &
                             (no400_cnt_reg == NO400_CYCLES - ONE);
      // While the violations are gone every closed frame sets AMI again.
      assign ami_set[gi] = ami_declare | (no8k_active_reg & frame_end);

      // Recovered clock falls at the chosen mark and rises half a period later.
      assign edge_event = recovered_edge_select ? (pulse & after_bpv_reg) : bpv;

      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          after_bpv_reg <= 1'b0;
          half_cnt_reg <= 20'h00000;
          rclk_reg <= 1'b1;
        end else begin
          if (bpv) begin
            after_bpv_reg <= 1'b1;
          end else if (pulse) begin
            after_bpv_reg <= 1'b0;
          end
          if (edge_event) begin
            half_cnt_reg <= 20'h00000;
            rclk_reg <= 1'b0;
          end else begin
            half_cnt_reg <= sat_inc(half_cnt_reg);
            if (half_cnt_reg == HALF8K_CYCLES - ONE) begin
              rclk_reg <= 1'b1;
            end
          end
        end
      end

      // Forwarded clock, invalidation and leaky bucket requests.
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          fwd_reg <= 1'b0;
          invalid_reg <= 1'b0;
          bucket_reg <= 1'b0;
        end else begin
          if (fmt_logic_reg[gi]) begin
            fwd_reg <= logic_clk_in[gi];
          end else begin
            fwd_reg <= rclk_reg & ~no8k_active_reg;
          end
          // The 400 Hz state takes no part in invalidation.
          invalid_reg <= ~fmt_logic_reg[gi] &
                         ((ami_invalidate_enable & ami_active_reg) |
                          (los_invalidate_enable & los_active_reg));
          bucket_reg <= bit_error_count_enable & frame_err & ~fmt_logic_reg[gi];
        end
      end

      assign recovered_clk_out[gi] = fwd_reg;
      assign clock_invalid[gi] = invalid_reg;
      assign leaky_bucket_inc[gi] = bucket_reg;
      assign missing_8k_active[gi] = no8k_active_reg;
    end
  endgenerate

  assign lf_set[`CCR_LF_LOS0] = los_set[0];
  assign lf_set[`CCR_LF_LOS1] = los_set[1];
  assign lf_set[`CCR_LF_AMI0] = ami_set[0];
  assign lf_set[`CCR_LF_AMI1] = ami_set[1];
  assign cs_set[`CCR_CS_NO8K0] = no8k_set[0];
  assign cs_set[`CCR_CS_NO8K1] = no8k_set[1];
  assign cs_set[`CCR_CS_NO400_0] = no400_set[0];
  assign cs_set[`CCR_CS_NO400_1] = no400_set[1];

  ccr_sticky #(
    .W(4)
  ) u_line_fault (
    .clk(clk),
    .arst_n(arst_n),
    .set(lf_set),
    .clr(line_fault_status_clear),
    .q(line_fault_status_register)
  );

  ccr_sticky #(
    .W(4)
  ) u_component (
    .clk(clk),
    .arst_n(arst_n),
    .set(cs_set),
    .clr(component_status_clear),
    .q(component_status_register)
  );

  // The request stays high while any enabled latched bit is set.
  assign interrupt_request_out = |(line_fault_status_register & line_fault_irq_enable) |
                                 |(component_status_register & component_irq_enable);

endmodule // ccr_top

// File: common/ccr_regs.vh
// Constants shared by the composite clock receiver files.
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// System clock period.
`define CCR_CLK_PERIOD_NS 8

// Loss of signal: no pulse for 32 us, which is 4000 system clock cycles.
`define CCR_LOS_CYCLES 20'h00FA0

// Missing 8 kHz component: no marking violation for 500 us, 62500 cycles.
`define CCR_NO8K_CYCLES 20'h0F424

// Missing 400 Hz component: no omitted violation for 5 ms, 625000 cycles.
`define CCR_NO400_CYCLES 20'h98968

// Half period of the recovered 8 kHz clock, 62.5 us rounded down to 7812 cycles.
`define CCR_HALF8K_CYCLES 20'h01E84

// Marks in one frame: seven normal marks and one violation.
`define CCR_MARKS_PER_FRAME 4'h8

// Line fault status bit positions.
`define CCR_LF_LOS0 0
`define CCR_LF_LOS1 1
`define CCR_LF_AMI0 2
`define CCR_LF_AMI1 3

// Component status bit positions.
`define CCR_CS_NO8K0 0
`define CCR_CS_NO8K1 1
`define CCR_CS_NO400_0 2
`define CCR_CS_NO400_1 3

// Reset values.
`define CCR_STATUS_RST 4'h0
`define CCR_FORMAT_RST 2'h0

`endif

// File: design/ccr_sync.v
// Two-flop synchroniser for the sliced line pulse indications.
`timescale 1ns/10ps
module ccr_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // ccr_sync

// File: design/ccr_sticky.v
// Latched status bits: hardware sets, software clears, a set beats a clear.
`timescale 1ns/10ps
module ccr_sticky #(
  parameter W = 4
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output wire [W-1:0] q
);

  reg [W-1:0] flag_reg;
  wire [W-1:0] flag_next;

  assign flag_next = (flag_reg & ~clr) | set;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= {W{1'b0}};
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign q = flag_reg;

endmodule // ccr_sticky

// File: testbench/ccr_monitor.sv
// Port-level assertions for the composite clock receiver.
`timescale 1ns/10ps
module ccr_monitor #(
  parameter [19:0] NO8K_CYCLES = 20'hF424,
  parameter [19:0] NO400_CYCLES = 20'h98968,
  parameter [19:0] HALF8K_CYCLES = 20'h1E84
) (
  input wire clk,
  input wire arst_n,
  input wire [1:0] cc_pos_pulse,
  input wire [1:0] cc_neg_pulse,
  input wire first_input_format_select,
  input wire bit_error_count_enable,
  input wire ami_invalidate_enable,
  input wire los_invalidate_enable,
  input wire [3:0] line_fault_irq_enable,
  input wire [3:0] component_irq_enable,
  input wire [3:0] line_fault_status_clear,
  input wire [3:0] component_status_clear,
  input wire [3:0] line_fault_status_register,
  input wire [3:0] component_status_register,
  input wire [1:0] recovered_clk_out,
  input wire [1:0] clock_invalid,
  input wire [1:0] leaky_bucket_inc,
  input wire [1:0] missing_8k_active,
  input wire interrupt_request_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire [7:0] st_all = {line_fault_status_register, component_status_register};
  wire [7:0] held_all = st_all & ~{line_fault_status_clear, component_status_clear};
  wire fmt0 = first_input_format_select;
  reg [12:0] quiet_reg;
  // Counts cycles with no mark on the first line, seen before synchronisation.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_reg <= 13'h0;
    end else if (cc_pos_pulse[0] || cc_neg_pulse[0]) begin
      quiet_reg <= 13'h0;
    end else if (quiet_reg != 13'h1FFF) begin
      quiet_reg <= quiet_reg + 13'h1;
    end
  end
  sequence s_no8k_held;
    (missing_8k_active[0] && !fmt0) [*3];
  endsequence
  sequence s_fell_cc;
    $fell(recovered_clk_out[0]) && !fmt0;
  endsequence
  irq_follows_bits_a:
    assert property (interrupt_request_out == |(st_all &
      {line_fault_irq_enable, component_irq_enable})) else $error("irq mismatch");
  status_bits_hold_a:
    assert property (1'b1 |=> (st_all & $past(held_all)) == $past(held_all))
      else $error("latched bit dropped");
  no8k_gates_clk_a:
    assert property (s_no8k_held |-> !recovered_clk_out[0]) else $error("clock while no 8k");
  half_low_a:
    assert property (s_fell_cc |=> (!recovered_clk_out[0]) [*8]) else $error("short low");
  leaky_enable_a:
    assert property (|leaky_bucket_inc |-> $past(bit_error_count_enable))
      else $error("leaky while off");
  invalid_cause_a:
    assert property (clock_invalid[0] |-> $past(ami_invalidate_enable || los_invalidate_enable))
      else $error("invalid while off");
  no8k_flag_a:
    assert property ($rose(missing_8k_active[0]) |-> ##[0:1] component_status_register[0])
      else $error("no8k bit not set");
  los_quiet_a:
    assert property ($rose(line_fault_status_register[0]) |-> quiet_reg >= 13'hF96)
      else $error("loss too early");
endmodule // ccr_monitor
bind ccr_top ccr_monitor #(.NO8K_CYCLES(NO8K_CYCLES), .NO400_CYCLES(NO400_CYCLES),
  .HALF8K_CYCLES(HALF8K_CYCLES)) i_ccr_monitor (.clk, .arst_n, .cc_pos_pulse, .cc_neg_pulse,
  .first_input_format_select, .bit_error_count_enable, .ami_invalidate_enable,
  .los_invalidate_enable, .line_fault_irq_enable, .component_irq_enable,
  .line_fault_status_clear, .component_status_clear, .line_fault_status_register,
  .component_status_register, .recovered_clk_out, .clock_invalid, .leaky_bucket_inc,
  .missing_8k_active, .interrupt_request_out);

// File: testbench/ccr_line_src.sv
// Composite clock line source with a mark every 4 cycles and selectable faults.
`timescale 1ns/10ps
module ccr_line_src (
  input wire clk,
  input wire [1:0] mode,
  output logic pos,
  output logic neg
);
  // Mode 0 marks every frame, 1 sends no violation, 2 is silent, 3 omits one in 16.
  logic [1:0] ph_reg = 2'h0;
  logic [2:0] idx_reg = 3'h0;
  logic [3:0] frm_reg = 4'h0;
  logic pol_reg = 1'b0;
  wire vio = idx_reg == 3'h7 && mode != 2'h1 && !(mode == 2'h3 && frm_reg == 4'h0);
  wire nxt = vio ? pol_reg : !pol_reg;
  initial begin
    pos = 1'b0;
    neg = 1'b0;
  end
  always @(posedge clk) begin
    ph_reg <= ph_reg + 2'h1;
    if (ph_reg == 2'h2) begin
      pos <= 1'b0;
      neg <= 1'b0;
    end else if (ph_reg == 2'h0 && mode != 2'h2) begin
      pol_reg <= nxt;
      pos <= nxt;
      neg <= !nxt;
      idx_reg <= idx_reg + 3'h1;
      frm_reg <= frm_reg + {3'h0, idx_reg == 3'h7};
    end
  end
endmodule // ccr_line_src

// File: testbench/tb_top.sv
// Directed bench for the composite clock receiver.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] md0 = 2'h3;
  logic [1:0] md1 = 2'h0;
  logic fmt0 = 1'b0, esel = 1'b0, berr = 1'b1, ainv = 1'b1, r0q = 1'b0;
  logic r1q = 1'b0, linv = 1'b1;
  logic [3:0] lie = 4'h0, cie = 4'h0, lcl = 4'h0, ccl = 4'h0;
  wire [1:0] pp, np, rck, inv, lky, n8;
  wire [3:0] lfs, css;
  wire irq;
  int num_errors = 0, compares = 0, cyc = 0, nl = 0, nr = 0, tf = 0, a, b;
  int nr1 = 0, c;
  initial forever #4 clk = ~clk;
  ccr_line_src i_src0 (.clk(clk), .mode(md0), .pos(pp[0]), .neg(np[0]));
  ccr_line_src i_src1 (.clk(clk), .mode(md1), .pos(pp[1]), .neg(np[1]));
  ccr_top #(.NO8K_CYCLES(20'hC8), .NO400_CYCLES(20'h7D0), .HALF8K_CYCLES(20'h14)) i_ccr_top (
    .clk(clk), .arst_n(arst_n), .cc_pos_pulse(pp), .cc_neg_pulse(np),
    .logic_clk_in({cyc[3], cyc[2]}), .first_input_format_select(fmt0),
    .second_input_format_select(1'b0), .recovered_edge_select(esel),
    .bit_error_count_enable(berr), .ami_invalidate_enable(ainv), .los_invalidate_enable(linv),
    .line_fault_irq_enable(lie), .component_irq_enable(cie), .line_fault_status_clear(lcl),
    .component_status_clear(ccl), .line_fault_status_register(lfs),
    .component_status_register(css), .recovered_clk_out(rck), .clock_invalid(inv),
    .leaky_bucket_inc(lky), .missing_8k_active(n8), .interrupt_request_out(irq));
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clr_all();
    lcl <= 4'hF;
    ccl <= 4'hF;
    run(1);
    lcl <= 4'h0;
    ccl <= 4'h0;
    run(1);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Counts leaky pulses, recovered rises and the cycle of the latest recovered fall.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    r0q <= rck[0];
    nl <= nl + int'(lky[0]);
    nr <= nr + int'(rck[0] && !r0q);
    r1q <= rck[1];
    nr1 <= nr1 + int'(rck[1] && !r1q);
    if (!rck[0] && r0q) begin
      tf <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    run(5);
    arst_n <= 1'b1;
    run(1);
    chk("reset", 4'h0, lfs | css | {inv, lky});
    $display("reset test done");
    run(300);
    clr_all();
    a = nl;
    b = nr;
    c = nr1;
    cie <= 4'h8;
    run(2400);
    chk("faults", 4'h0, lfs);
    chk("components", 4'h8, css);
    chk("inv_irq", 4'h1, {n8[1], inv, irq});
    chk("leaky", 4'h1, {3'h0, (nl - a) inside {4, 5}});
    chk("clock", 4'h1, {3'h0, (nr - b) inside {[68:76]}});
    chk("clock1", 4'h1, {3'h0, (nr1 - c) inside {[74:76]}});
    cie <= 4'h0;
    run(100);
    a = tf % 32;
    esel <= 1'b1;
    run(100);
    b = tf % 32;
    chk("edge", 4'h4, 4'((b - a + 32) % 32));
    $display("steady line test done");
    md0 <= 2'h2;
    lie <= 4'h1;
    run(150);
    chk("no8k_early", 4'h0, {3'h0, css[0]});
    run(150);
    chk("no8k", 4'hC, {css[0], n8[0], rck[0], lfs[0]});
    run(3600);
    chk("los_early", 4'h0, {lfs[0], inv[0], irq, 1'b0});
    run(200);
    chk("los", 4'hE, {lfs[0], inv[0], irq, 1'b0});
    linv <= 1'b0;
    run(3);
    chk("los_noinv", 4'h2, {2'h0, lfs[0], inv[0]});
    linv <= 1'b1;
    md0 <= 2'h3;
    run(100);
    chk("los_held", 4'hA, {lfs[0], inv[0], irq, 1'b0});
    clr_all();
    chk("los_clr", 4'h0, {lfs[0], inv[0], irq, 1'b0});
    $display("loss test done");
    lie <= 4'h0;
    md0 <= 2'h1;
    run(300);
    chk("ami", 4'hE, {lfs[2], n8[0], inv[0], rck[0]});
    clr_all();
    run(40);
    chk("ami_again", 4'h1, {3'h0, lfs[2]});
    a = nl;
    b = nr;
    fmt0 <= 1'b1;
    run(100);
    chk("format", 4'h1, {inv[0], nl != a, 1'b0, (nr - b) > 5});
    fmt0 <= 1'b0;
    md0 <= 2'h3;
    berr <= 1'b0;
    a = nl;
    run(600);
    chk("recover", 4'h0, {inv[0], n8[0], nl != a, 1'b0});
    $display("violation test done");
    tally_and_finish();
  end
endmodule // tb_top
